/* File: verilog/cte_core.sv */
`timescale 1ns/1ns
`include "cte_defines.svh"
// Overview of operation
// - late phase lasts late_segment_len+1 quanta, nonzero
// - early phase and propagation last field+1 quanta
// - resync adjustment limited to resync_jump_limit+1 quanta
// - resync at most once per bit, on the first recessive-to-dominant edge outside the sync phase
// - quantum is quantum_divider+1 master clocks
// - one sample, or three centred samples
// - divider zero forces single sampling
// - timer register returns 16-bit counter
// - capture timer at frame start or end
// - capture sets flag, masked interrupt follows
// - status read clears capture flag
// - re-enabling controller resets timestamp
// - receiver error adds one, flag bit errors excluded
// - receiver adds eight for flag cases
// - long dominant run after flag adds eight
// - good reception decrements or reloads rx tally
// - transmitter error flag adds eight, two exceptions
// - good transmission decrements tx tally
// - mailbox request bits start transfer per type
// - request clears mailbox ready and aborted
// - transmit in priority order, lowest number ties
// - counter clear resets and restarts timer
module cte_core
  import cte_pkg::*;
#(
  parameter int MAILBOXES = 16
) (
  input  wire logic        ref_clk,         // master_clk
  input  wire logic        reset,           // synchronous, active high
  input  wire logic [3:0]  avs_address,     // word address
  input  wire logic        avs_read,        // read strobe
  input  wire logic        avs_write,       // write strobe
  input  wire logic [31:0] avs_writedata,   // write data
  input  wire logic [3:0]  avs_byteenable,  // byte lanes
  output logic      [31:0] avs_readdata,    // read data
  output logic             avs_waitrequest, // stall
  output logic      [1:0]  avs_response,    // 00 ok, 10 slave error
  input  wire logic        can_rx,          // bus level from transceiver, 0 dominant
  input  cte_evt_t         evt,             // protocol events from the frame engine
  input  wire logic [2:0]  mb_prio [16],    // mailbox priority, higher first
  input  wire logic        mb_is_tx [16],   // mailbox type sends a frame on request
  output logic      [15:0] mb_armed,        // mailbox transfer pending
  output logic      [4:0]  tx_mailbox,      // mailbox now sending
  output logic             tx_start,        // tx_mailbox valid
  output logic             sample_bit,      // sampled bus level
  output logic             sample_strobe,   // one pulse per sample point
  output logic             timer_irq        // capture interrupt
);
  if (MAILBOXES != 16) begin : g_bad_mailboxes
    $error("cte_core serves exactly 16 mailboxes");
  end

  cte_state_t s, next_s;
  logic [1:0] resp_q;

  function automatic logic [7:0] sat_add8(input logic [7:0] v);
    logic [8:0] t;
    t = {1'b0, v} + {1'b0, `CTE_ERR_STEP};
    return t[8] ? 8'hFF : t[7:0];
  endfunction

  function automatic logic [7:0] sat_inc(input logic [7:0] v);
    return (v == 8'hFF) ? v : v + 8'h01;
  endfunction

  logic [1:0]  late_len, early_len, wire_len, jump_len;
  logic [6:0]  qdiv;
  logic        triple;
  logic        edge_seen, q_tick, mid_sample, phase_err_pos;
  logic [7:0]  jump_q, sel_prio;
  logic [4:0]  best;
  logic [2:0]  best_pr;
  logic        best_ok;
  logic        rd_hit, wr_hit;

  always_comb begin
    late_len  = s.bit_timing[`CTE_BT_LATE_LSB +: 2];
    early_len = s.bit_timing[`CTE_BT_EARLY_LSB +: 2];
    wire_len  = s.bit_timing[`CTE_BT_WIRE_LSB +: 2];
    jump_len  = s.bit_timing[`CTE_BT_JUMP_LSB +: 2];
    qdiv      = s.bit_timing[`CTE_BT_QDIV_LSB +: 7];
    triple    = s.bit_timing[`CTE_BT_TRIPLE_BIT] && (qdiv != 7'h00);
    jump_q    = {6'h00, jump_len} + 8'h01;
    q_tick    = (s.qcnt == qdiv);
    edge_seen = s.ctrl_on && s.bus_prev && !can_rx;
    phase_err_pos = (s.seg != CTE_SYNC);
    mid_sample = (s.seg == CTE_EARLY) && (s.tqcnt == s.seg_len) && (s.qcnt == qdiv);
    best = 5'h00; best_pr = 3'h0; best_ok = 1'b0; sel_prio = 8'h00;
    for (int i = 0; i < 16; i++) begin
      if (s.pend[i] && mb_is_tx[i] && (!best_ok || mb_prio[i] > best_pr)) begin
        best = 5'(i); best_pr = mb_prio[i]; best_ok = 1'b1;
      end
    end
    rd_hit = avs_read && s.wait_req;
    wr_hit = avs_write && s.wait_req;
  end

  always_comb begin
    next_s = s;
    next_s.bus_prev = can_rx;
    next_s.wait_req = !s.wait_req && (avs_read || avs_write);
    // free timer
    next_s.timer = s.timer + 16'h0001;
    // bit timing
    next_s.qcnt = q_tick ? 7'h00 : s.qcnt + 7'h01;
    next_s.smp_sh = {s.smp_sh[1:0], can_rx};
    if (q_tick) begin
      next_s.tqcnt = s.tqcnt + 8'h01;
      if (s.tqcnt == s.seg_len) begin
        next_s.tqcnt = 8'h00;
        case (s.seg)
          CTE_SYNC:  begin next_s.seg = CTE_PROP;  next_s.seg_len = {6'h00, wire_len}; end
          CTE_PROP:  begin next_s.seg = CTE_EARLY; next_s.seg_len = {6'h00, early_len}; end
          CTE_EARLY: begin next_s.seg = CTE_LATE;  next_s.seg_len = {6'h00, late_len}; end
          CTE_LATE:  begin next_s.seg = CTE_SYNC;  next_s.seg_len = 8'h00; next_s.resynced = 1'b0; end
          default:   begin next_s.seg = CTE_SYNC;  next_s.seg_len = 8'h00; end
        endcase
      end
    end
    if (edge_seen && !s.resynced && phase_err_pos) begin
      next_s.resynced = 1'b1;
      if (s.seg == CTE_LATE) begin
        // edge early: shorten late phase by at most the jump width
        if (s.seg_len - s.tqcnt <= jump_q) begin
          next_s.seg = CTE_SYNC; next_s.seg_len = 8'h00; next_s.tqcnt = 8'h00;
          next_s.resynced = 1'b0;
        end else next_s.seg_len = s.seg_len - jump_q;
      end else if (s.seg == CTE_EARLY) begin
        // edge late: lengthen early phase
        next_s.seg_len = s.seg_len + ((s.tqcnt < jump_q) ? s.tqcnt : jump_q);
      end
    end
    if (mid_sample) begin
      next_s.rx_bit = triple ? ((s.smp_sh[0] & s.smp_sh[1]) | (s.smp_sh[0] & can_rx) |
                                (s.smp_sh[1] & can_rx)) : s.smp_sh[0];
    end
    // timestamp
    if ((evt.sof && !s.cap_eof) || (evt.eof && s.cap_eof)) begin
      next_s.stamp = s.timer;
      next_s.cap_flag = 1'b1;
    end else if (rd_hit && avs_address == `CTE_OFS_STATUS) next_s.cap_flag = 1'b0;
    // error tallies
    if (evt.rx_error && !evt.flag_bit_err) next_s.rx_fault_tally = sat_inc(s.rx_fault_tally);
    if (evt.rx_err_dom1 || evt.flag_bit_err) next_s.rx_fault_tally = sat_add8(s.rx_fault_tally);
    if (evt.tx_error && !evt.tx_except) next_s.tx_fault_tally = sat_add8(s.tx_fault_tally);
    if (evt.flag_bit_err) next_s.tx_fault_tally = sat_add8(s.tx_fault_tally);
    if (evt.flag_end) next_s.dom_cnt = 5'h00;
    else if (evt.flag_dom_bit) begin
      next_s.dom_cnt = s.dom_cnt + 5'h01;
      if ((!evt.flag_passive && s.dom_cnt + 5'h01 == `CTE_DOM_ACTIVE_LIM) ||
          (evt.flag_passive && s.dom_cnt + 5'h01 == `CTE_DOM_PASSIVE_LIM)) begin
        next_s.rx_fault_tally = sat_add8(s.rx_fault_tally);
        next_s.tx_fault_tally = sat_add8(s.tx_fault_tally);
        // every 8 more dominant bits reach the limit again
        next_s.dom_cnt = evt.flag_passive ? (`CTE_DOM_PASSIVE_LIM - 5'h08) :
                                            (`CTE_DOM_ACTIVE_LIM - 5'h08);
      end
    end
    if (evt.rx_ok) begin
      if (s.rx_fault_tally > `CTE_REC_PASSIVE_MAX) next_s.rx_fault_tally = `CTE_REC_RELOAD;
      else if (s.rx_fault_tally != 8'h00) next_s.rx_fault_tally = s.rx_fault_tally - 8'h01;
    end
    if (evt.tx_ok && s.tx_fault_tally != 8'h00) next_s.tx_fault_tally = s.tx_fault_tally - 8'h01;
    // mailbox sequencing
    if (s.tx_busy && evt.tx_done) begin
      next_s.tx_busy = 1'b0;
      next_s.pend[s.tx_sel[3:0]] = 1'b0;
      next_s.ready_flag[s.tx_sel[3:0]] = 1'b1;
    end else if (!s.tx_busy && best_ok && s.ctrl_on) begin
      next_s.tx_busy = 1'b1;
      next_s.tx_sel = best;
    end
    // register writes
    if (wr_hit) begin
      case (avs_address)
        `CTE_OFS_BIT_TIMING: begin
          for (int b = 0; b < 4; b++)
            if (avs_byteenable[b]) next_s.bit_timing[b*8 +: 8] = avs_writedata[b*8 +: 8];
        end
        `CTE_OFS_CTRL: if (avs_byteenable[0]) begin
          next_s.ctrl_on  = avs_writedata[`CTE_CTRL_ON_BIT];
          next_s.cap_eof  = avs_writedata[`CTE_CTRL_EOF_BIT];
          next_s.cap_mask = avs_writedata[`CTE_CTRL_MASK_BIT];
          if (avs_writedata[`CTE_CTRL_ON_BIT] && !s.ctrl_on) next_s.stamp = 16'h0000;
        end
        `CTE_OFS_XFER_CMD: begin
          for (int m = 0; m < 16; m++) begin
            if (avs_byteenable[m/8] && avs_writedata[m]) begin
              next_s.pend[m] = 1'b1;
              next_s.ready_flag[m] = 1'b0;
              next_s.abort_flag[m] = 1'b0;
            end
          end
          if (avs_byteenable[3] && avs_writedata[`CTE_XFER_CLR_BIT])
            next_s.timer = 16'h0000;
        end
        default: ;
      endcase
    end
    // read data latched in the stall cycle so it stands while waitrequest is low
    next_s.rdata = 32'h0000_0000;
    if (avs_read && !s.wait_req) begin
      case (avs_address)
        `CTE_OFS_BIT_TIMING:  next_s.rdata = s.bit_timing;
        `CTE_OFS_FREE_TIMER:  next_s.rdata = {16'h0000, s.timer};
        `CTE_OFS_TIMESTAMP:   next_s.rdata = {16'h0000, s.stamp};
        `CTE_OFS_ERR_TALLIES: next_s.rdata = {8'h00, s.tx_fault_tally, 8'h00, s.rx_fault_tally};
        `CTE_OFS_CTRL:        next_s.rdata = {29'h0, s.cap_mask, s.cap_eof, s.ctrl_on};
        `CTE_OFS_STATUS:      next_s.rdata = {31'h0, s.cap_flag};
        `CTE_OFS_MB_STATUS:   next_s.rdata = {s.abort_flag, s.ready_flag};
        default:              next_s.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s <= '0;
      s.seg <= CTE_SYNC;
      s.bus_prev <= 1'b1;
      s.rx_bit <= 1'b1;
      s.bit_timing <= `CTE_BT_RESET;
      resp_q <= 2'b00;
    end else begin
      s <= next_s;
      resp_q <= ((avs_read || avs_write) && !s.wait_req &&
                 (avs_address > `CTE_OFS_MB_STATUS ||
                 (avs_read && avs_address == `CTE_OFS_XFER_CMD))) ? 2'b10 : 2'b00;
    end
  end

  assign avs_readdata    = s.rdata;
  assign avs_waitrequest = (avs_read || avs_write) && !s.wait_req;
  assign avs_response    = resp_q;
  assign mb_armed        = s.pend;
  assign tx_mailbox      = s.tx_sel;
  assign tx_start        = s.tx_busy;
  assign sample_bit      = s.rx_bit;
  assign sample_strobe   = s.ctrl_on && (s.seg == CTE_LATE) && (s.tqcnt == 8'h00) &&
                           (s.qcnt == 7'h00);
  assign timer_irq       = s.cap_flag && s.cap_mask;
endmodule // cte_core

/* File: verilog/cte_defines.svh */
`ifndef CTE_DEFINES_SVH
`define CTE_DEFINES_SVH
// register word offsets
`define CTE_OFS_BIT_TIMING   4'h0
`define CTE_OFS_FREE_TIMER   4'h1
`define CTE_OFS_TIMESTAMP    4'h2
`define CTE_OFS_ERR_TALLIES  4'h3
`define CTE_OFS_XFER_CMD     4'h4
`define CTE_OFS_CTRL         4'h5
`define CTE_OFS_STATUS       4'h6
`define CTE_OFS_MB_STATUS    4'h7
// bit timing field positions
`define CTE_BT_LATE_LSB      0
`define CTE_BT_WIRE_LSB      8
`define CTE_BT_EARLY_LSB     4
`define CTE_BT_JUMP_LSB      12
`define CTE_BT_QDIV_LSB      16
`define CTE_BT_TRIPLE_BIT    24
// control / status bits
`define CTE_CTRL_ON_BIT      0
`define CTE_CTRL_EOF_BIT     1
`define CTE_CTRL_MASK_BIT    2
`define CTE_XFER_CLR_BIT     31
// reset values and counts
`define CTE_BT_RESET         32'h0000_0000
`define CTE_REC_PASSIVE_MAX  8'd127
`define CTE_REC_RELOAD       8'd119
`define CTE_ERR_STEP         8'd8
`define CTE_DOM_ACTIVE_LIM   5'd14
`define CTE_DOM_PASSIVE_LIM  5'd8
`endif

/* File: verilog/cte_pkg.sv */
package cte_pkg;
  typedef struct packed {
    logic       sof;          // start of frame seen
    logic       eof;          // end of frame seen
    logic       rx_error;     // receiver error detected
    logic       rx_err_dom1;  // dominant bit right after own error flag
    logic       flag_bit_err; // bit error while sending active error/overload flag
    logic       flag_dom_bit; // dominant bit seen after error/overload flag
    logic       flag_passive; // the flag was a passive error flag
    logic       flag_end;     // the dominant sequence ended
    logic       tx_error;     // transmitter sends an error flag
    logic       tx_except;    // exempt case (passive ack or arbitration stuff)
    logic       rx_ok;        // successful reception
    logic       tx_ok;        // successful transmission
    logic       tx_done;      // current mailbox transmission finished
  } cte_evt_t;
  typedef enum logic [3:0] {
    CTE_SYNC  = 4'b0001,
    CTE_PROP  = 4'b0010,
    CTE_EARLY = 4'b0100,
    CTE_LATE  = 4'b1000
  } cte_seg_t;
  typedef struct packed {
    logic [31:0] bit_timing;
    logic        ctrl_on;
    logic        cap_eof;
    logic        cap_mask;
    logic [15:0] timer;
    logic [15:0] stamp;
    logic        cap_flag;
    logic [7:0]  rx_fault_tally;
    logic [7:0]  tx_fault_tally;
    logic [4:0]  dom_cnt;
    logic [15:0] pend;
    logic [15:0] ready_flag;
    logic [15:0] abort_flag;
    logic [4:0]  tx_sel;
    logic        tx_busy;
    cte_seg_t    seg;
    logic [6:0]  qcnt;
    logic [7:0]  tqcnt;
    logic [7:0]  seg_len;
    logic [2:0]  smp_sh;
    logic        rx_bit;
    logic        bus_prev;
    logic        resynced;
    logic        wait_req;
    logic [31:0] rdata;
  } cte_state_t;
endpackage

/* File: dv/cte_core_assertions.sv */
`timescale 1ns/1ns
module cte_core_chk
  import cte_pkg::*;
(
  input wire logic        ref_clk,         // clock
  input wire logic        reset,           // reset
  input wire logic [3:0]  avs_address,     // address
  input wire logic        avs_read,        // read
  input wire logic        avs_write,       // write
  input wire logic        avs_waitrequest, // stall
  input wire logic [31:0] avs_readdata,    // read data
  input cte_evt_t         evt,             // events
  input wire logic [15:0] mb_armed,        // pending
  input wire logic [4:0]  tx_mailbox,      // sending
  input wire logic        tx_start,        // busy
  input wire logic        sample_strobe,   // sample
  input wire logic        timer_irq        // irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic acc;
  logic cap;
  logic arm;
  assign acc = avs_read || avs_write;
  assign cap = evt.sof || evt.eof;
  assign arm = avs_write && !avs_waitrequest && avs_address == 4'h4;
  chk_bus_answer: assert property (acc && avs_waitrequest |=> !avs_waitrequest)
    else $error("late answer");
  chk_timer_high: assert property (avs_read && !avs_waitrequest && avs_address == 4'h1
    |-> avs_readdata[31:16] == 16'h0) else $error("timer high bits");
  chk_tally_gaps: assert property (avs_read && !avs_waitrequest && avs_address == 4'h3
    |-> avs_readdata[31:24] == 8'h0 && avs_readdata[15:8] == 8'h0) else $error("tally gaps");
  chk_irq_cause: assert property ($rose(timer_irq)
    |-> $past(cap) || $past(cap, 2) || $past(acc) || $past(acc, 2)) else $error("irq cause");
  chk_irq_clear: assert property ($fell(timer_irq) |-> $past(acc) || $past(acc, 2))
    else $error("irq drop");
  chk_arm_cause: assert property (|(mb_armed & ~$past(mb_armed))
    |-> $past(arm) || $past(arm, 2)) else $error("arm cause");
  chk_tx_hold: assert property (tx_start && !evt.tx_done |=> tx_start && $stable(tx_mailbox))
    else $error("tx hold");
  chk_strobe_pulse: assert property (sample_strobe |=> !sample_strobe)
    else $error("strobe width");
endmodule // cte_core_chk

/* File: dv/cte_node_model.sv */
`timescale 1ns/1ns
module cte_node_model
  import cte_pkg::*;
(
  input wire logic       ref_clk,    // clock
  input wire logic       reset,      // reset
  input wire logic       tx_start,   // device sending
  input wire logic [4:0] tx_mailbox, // mailbox sending
  input wire logic       slow,       // long frames
  input cte_evt_t        inject,     // bench events
  output logic           can_rx,     // bus level
  output cte_evt_t       evt         // events to device
);
  logic [5:0] cnt;
  logic [4:0] last;
  logic       busy;
  logic       finish;
  cte_evt_t   next_evt;
  assign finish = !reset && tx_start && busy && (cnt == 6'h0);
  always_comb begin
    next_evt         = inject;
    next_evt.tx_done = inject.tx_done | finish;
    next_evt.tx_ok   = inject.tx_ok | finish;
  end
  always_ff @(posedge ref_clk) begin
    evt <= next_evt;
    if (reset || !tx_start) begin
      busy   <= 1'b0;
      last   <= 5'h1F;
      can_rx <= 1'b1;
    end else if (!busy && tx_mailbox != last) begin
      busy <= 1'b1;
      cnt  <= slow ? 6'h1E : 6'h02;
    end else if (busy && cnt != 6'h0) begin
      cnt    <= cnt - 6'h1;
      can_rx <= ~can_rx;
    end else if (busy) begin
      busy        <= 1'b0;
      last        <= tx_mailbox;
      can_rx      <= 1'b1;
    end
  end
endmodule // cte_node_model

/* File: dv/tb.sv */
`timescale 1ns/1ns
module tb;
  import cte_pkg::*;
  logic        ref_clk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0, slow = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [2:0]  mb_prio [16];
  logic        mb_is_tx [16];
  cte_evt_t    inject = '0, evt;
  logic        avs_waitrequest, can_rx, tx_start, sample_strobe, timer_irq, was_start = 1'b0;
  logic [1:0]  avs_response;
  logic [15:0] mb_armed, txm, armed_exp = 16'h0;
  logic [4:0]  tx_mailbox, was_mb = 5'h0;
  logic [31:0] exp_rd [$], exp_mb [$];
  int          n_mismatch = 0, checks_done = 0;
  always #5 ref_clk = ~ref_clk;
  cte_core dut (.ref_clk(ref_clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .can_rx(can_rx), .evt(evt), .mb_prio(mb_prio),
    .mb_is_tx(mb_is_tx),
    .mb_armed(mb_armed), .tx_mailbox(tx_mailbox), .tx_start(tx_start), .sample_bit(),
    .sample_strobe(sample_strobe), .timer_irq(timer_irq));
  cte_node_model node (.ref_clk(ref_clk), .reset(reset), .tx_start(tx_start),
    .tx_mailbox(tx_mailbox), .slow(slow), .inject(inject), .can_rx(can_rx), .evt(evt));
  task automatic check(string what, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
    @(posedge ref_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !w;
    avs_write     <= w;
    @(posedge ref_clk iff !avs_waitrequest);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, logic [31:0] e);
    exp_rd.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic ev(cte_evt_t e, int n);
    repeat (n) begin
      @(posedge ref_clk);
      inject <= e;
      @(posedge ref_clk);
      inject <= '0;
    end
  endtask
  task automatic report_and_stop;
    if (exp_rd.size() != 0 || exp_mb.size() != 0) n_mismatch++;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // results are matched in order against what the driver queued
  always @(posedge ref_clk) begin
    if (avs_read && !avs_waitrequest) begin
      check("readdata", exp_rd.size() ? exp_rd.pop_front() : 32'hX, avs_readdata);
      check("response", (avs_address > 4'h7 || avs_address == 4'h4) ? 32'h2 : 32'h0,
            {30'h0, avs_response});
    end
    if (tx_start && (!was_start || was_mb != tx_mailbox))
      check("tx_mailbox", exp_mb.size() ? exp_mb.pop_front() : 32'hX, {27'h0, tx_mailbox});
    was_start <= tx_start;
    was_mb    <= tx_mailbox;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    logic [31:0] bt;
    logic [15:0] r, c, rdy;
    logic [2:0]  p [16];
    int          best;
    void'($urandom(22));
    rdy = 16'h0;
    foreach (mb_prio[i]) begin
      mb_prio[i]  = 3'h0;
      mb_is_tx[i] = ($urandom % 4) != 0;
      txm[i]      = mb_is_tx[i];
    end
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    rd(4'h3, 32'h0);
    rd(4'hF, 32'h0);
    bt = ($urandom & 32'h017F_3333) | 32'h0001_0001;
    bus(1'b1, 4'h0, bt);
    rd(4'h0, bt);
    bus(1'b1, 4'h5, 32'h5);
    ev('{sof: 1, default: 0}, 1);
    repeat (3) @(posedge ref_clk);
    check("timer_irq", 32'h1, {31'h0, timer_irq});
    rd(4'h6, 32'h1);
    rd(4'h6, 32'h0);
    repeat (2) @(posedge ref_clk);
    check("timer_irq", 32'h0, {31'h0, timer_irq});
    bus(1'b1, 4'h5, 32'h7);
    ev('{sof: 1, default: 0}, 1);
    rd(4'h6, 32'h0);
    ev('{eof: 1, default: 0}, 1);
    rd(4'h6, 32'h1);
    bus(1'b1, 4'h5, 32'h0);
    bus(1'b1, 4'h5, 32'h1);
    rd(4'h2, 32'h0);
    for (int b = 0; b < 2; b++) begin
      @(posedge ref_clk);
      slow <= (b == 0);
      foreach (p[i]) begin
        p[i] = 3'($urandom);
        mb_prio[i] <= p[i];
      end
      r = 16'($urandom);
      c = r;
      armed_exp |= r & ~txm;
      for (int k = 0; k < 16; k++) begin
        best = -1;
        foreach (p[i]) if (c[i] && txm[i] && (best < 0 || p[i] > p[best])) best = i;
        if (best >= 0) exp_mb.push_back(32'(best));
        if (best >= 0) c[best] = 1'b0;
      end
      bus(1'b1, 4'h4, {16'h0, r});
      rd(4'h7, {16'h0, rdy & ~r});
      for (int k = 0; k < 2000 && (exp_mb.size() > 0 || tx_start); k++) @(posedge ref_clk);
      repeat (3) @(posedge ref_clk);
      check("mb_armed", {16'h0, armed_exp}, {16'h0, mb_armed});
      rdy = (rdy & ~r) | (r & txm);
    end
    ev('{rx_ok: 1, tx_ok: 1, default: 0}, 1);
    rd(4'h3, 32'h0);
    ev('{rx_error: 1, default: 0}, 1);
    ev('{rx_error: 1, flag_bit_err: 1, default: 0}, 1);
    ev('{rx_err_dom1: 1, default: 0}, 1);
    ev('{tx_error: 1, default: 0}, 1);
    ev('{tx_error: 1, tx_except: 1, default: 0}, 1);
    ev('{flag_dom_bit: 1, default: 0}, 22);
    ev('{flag_end: 1, default: 0}, 1);
    ev('{rx_ok: 1, tx_ok: 1, default: 0}, 1);
    rd(4'h3, {8'h0, 8'h1F, 8'h0, 8'h20});
    ev('{rx_err_dom1: 1, default: 0}, 13);
    ev('{rx_ok: 1, default: 0}, 1);
    ev('{flag_dom_bit: 1, flag_passive: 1, default: 0}, 8);
    rd(4'h3, {8'h0, 8'h27, 8'h0, 8'h7F});
    bus(1'b1, 4'h4, 32'h8000_0000);
    rd(4'h1, 32'h1);
    repeat (5) @(posedge ref_clk);
    report_and_stop();
  end
endmodule // tb
bind cte_core cte_core_chk chk (.ref_clk(ref_clk), .reset(reset), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .avs_readdata(avs_readdata), .evt(evt), .mb_armed(mb_armed), .tx_mailbox(tx_mailbox),
  .tx_start(tx_start), .sample_strobe(sample_strobe), .timer_irq(timer_irq));
